// File: swpmm_top.sv
`default_nettype none

module swpmm_top
  import swpmm_pkg::*;
(
  // Clock and reset
  input  wire logic                                        clk_sys_i,
  input  wire logic                                        rst_n_i,
  // Register port
  input  wire logic [swpmm_pkg::AW-1:0]                    reg_addr_i,
  input  wire logic [swpmm_pkg::RW-1:0]                    reg_wdata_i,
  input  wire logic                                        reg_wr_i,
  input  wire logic                                        reg_rd_i,
  output logic      [swpmm_pkg::RW-1:0]                    reg_rdata_o,
  // Port modules
  input  wire logic [swpmm_pkg::NPM-1:0][swpmm_pkg::DW-1:0] port_module_tx_data_i,
  input  wire logic [swpmm_pkg::NPM-1:0]                    port_module_tx_valid_i,
  output logic      [swpmm_pkg::NPM-1:0][swpmm_pkg::DW-1:0] port_module_rx_data_o,
  output logic      [swpmm_pkg::NPM-1:0]                    port_module_rx_valid_o,
  output logic      [swpmm_pkg::NPM-1:0]                    port_module_rx_link_o,
  output logic      [swpmm_pkg::NPM-1:0]                    port_module_rst_o,
  output logic      [swpmm_pkg::NDUAL-1:0]                  pcs_keep_active_o,
  output logic      [swpmm_pkg::NDUAL-1:0]                  half_duplex_quick_path_disable_o,
  // One-gig serial macros
  input  wire logic [swpmm_pkg::NSER-1:0][swpmm_pkg::DW-1:0] ser1g_rx_data_i,
  input  wire logic [swpmm_pkg::NSER-1:0]                    ser1g_rx_valid_i,
  input  wire logic [swpmm_pkg::NSER-1:0]                    ser1g_rx_link_i,
  output logic      [swpmm_pkg::NSER-1:0][swpmm_pkg::DW-1:0] ser1g_tx_data_o,
  output logic      [swpmm_pkg::NSER-1:0]                    ser1g_tx_valid_o,
  // Copper transceivers
  input  wire logic [swpmm_pkg::NCU-1:0][swpmm_pkg::DW-1:0] copper_rx_data_i,
  input  wire logic [swpmm_pkg::NCU-1:0]                    copper_rx_valid_i,
  input  wire logic [swpmm_pkg::NCU-1:0]                    copper_rx_link_i,
  output logic      [swpmm_pkg::NCU-1:0][swpmm_pkg::DW-1:0] copper_tx_data_o,
  output logic      [swpmm_pkg::NCU-1:0]                    copper_tx_valid_o,
  // First high-speed macro, quad lanes
  input  wire logic [swpmm_pkg::NQUAD-1:0][swpmm_pkg::DW-1:0] quad_rx_data_i,
  input  wire logic [swpmm_pkg::NQUAD-1:0]                    quad_rx_valid_i,
  input  wire logic [swpmm_pkg::NQUAD-1:0]                    quad_rx_link_i,
  output logic      [swpmm_pkg::NQUAD-1:0][swpmm_pkg::DW-1:0] quad_tx_data_o,
  output logic      [swpmm_pkg::NQUAD-1:0]                    quad_tx_valid_o,
  // Second high-speed macro
  input  wire logic [swpmm_pkg::DW-1:0]                    hss_rx_data_i,
  input  wire logic                                        hss_rx_valid_i,
  input  wire logic                                        hss_rx_link_i,
  output logic      [swpmm_pkg::DW-1:0]                    hss_tx_data_o,
  output logic                                             hss_tx_valid_o,
  // Host link
  input  wire logic [swpmm_pkg::DW-1:0]                    host_link_tx_data_i,
  input  wire logic                                        host_link_tx_valid_i,
  output logic      [swpmm_pkg::DW-1:0]                    host_link_rx_data_o,
  output logic                                             host_link_rx_valid_o,
  output logic                                             host_link_rx_link_o,
  // Logical port identifiers
  output logic      [swpmm_pkg::NPORT-1:0][swpmm_pkg::PORT_W-1:0] logical_port_identifier_o
);

  import swpmm_pkg::*;

  ////////////////////////////////////////////////////////////////////////////////
  // Configuration state
  logic                            quad_serial_mode_enable_r;
  logic                            host_link_mode_enable_r;
  logic [NDUAL-1:0]                copper_sel_r;
  logic [NDUAL-1:0]                pcs_keep_r;
  logic [NDUAL-1:0]                hdx_dis_r;
  logic [NPM-1:0]                  pm_rst_r;
  logic [NPORT-1:0][PORT_W-1:0]    lpid_r;
  logic [RW-1:0]                   rdata_r;
  logic [RW-1:0]                   rdata_nxt;
  swpmm_src_t                      src_r   [NPM];
  swpmm_src_t                      src_nxt [NPM];
  logic [NPM-1:0]                  conn;
  logic                            host_act;
  logic                            quad_act;

  ////////////////////////////////////////////////////////////////////////////////
  // Register writes
  always_ff @(posedge clk_sys_i)
  begin
    if (!rst_n_i)
    begin
      quad_serial_mode_enable_r <= 1'b0;
      host_link_mode_enable_r   <= 1'b0;
      copper_sel_r              <= CU_SEL_RST;
      pcs_keep_r                <= KEEP_RST;
    end
    else if (reg_wr_i && reg_addr_i == OFS_MACRO_CFG)
    begin
      quad_serial_mode_enable_r <= reg_wdata_i[QUAD_BIT];
      host_link_mode_enable_r   <= reg_wdata_i[HOST_BIT];
      copper_sel_r              <= reg_wdata_i[CU_SEL_LSB +: NDUAL];
      pcs_keep_r                <= reg_wdata_i[KEEP_LSB +: NDUAL];
    end
  end

  always_ff @(posedge clk_sys_i)
  begin
    if (!rst_n_i)
      pm_rst_r <= PORT_RST_RST;
    else if (reg_wr_i && reg_addr_i == OFS_PORT_RST)
      pm_rst_r <= reg_wdata_i[NPM-1:0];
  end

  always_ff @(posedge clk_sys_i)
  begin
    if (!rst_n_i)
      hdx_dis_r <= HDX_DIS_RST;
    else if (reg_wr_i && reg_addr_i == OFS_HDX_CFG)
      hdx_dis_r <= reg_wdata_i[NDUAL-1:0];
  end

  always_ff @(posedge clk_sys_i)
  begin
    if (!rst_n_i)
    begin
      for (int n = 0; n < NPORT; n++)
        lpid_r[n] <= PORT_W'(n);
    end
    else if (reg_wr_i)
    begin
      for (int n = 0; n < NPORT; n++)
        if (reg_addr_i == OFS_LPID_BASE + AW'(4 * n))
          lpid_r[n] <= reg_wdata_i[PORT_W-1:0];
    end
  end

  ////////////////////////////////////////////////////////////////////////////////
  // Macro selection per port module
  always_comb
  begin
    for (int p = 0; p < NPM; p++)
      src_nxt[p] = SRC_NONE;
    for (int p = 0; p < NDUAL; p++)
      src_nxt[p] = copper_sel_r[p] ? SRC_COPPER : SRC_SER1G;
    for (int p = NDUAL; p < QUAD_BASE + NQUAD; p++)
    begin
      if (quad_serial_mode_enable_r)
        src_nxt[p] = SRC_QUAD;
      else if (p < NSER)
        src_nxt[p] = SRC_SER1G;
      else
        src_nxt[p] = SRC_NONE;
    end
    src_nxt[PM_P10] = host_link_mode_enable_r ? SRC_NONE : SRC_HSS;
  end

  // Selection only moves while the port module sits in reset
  always_ff @(posedge clk_sys_i)
  begin
    if (!rst_n_i)
    begin
      for (int p = 0; p < NPM; p++)
        src_r[p] <= SRC_NONE;
    end
    else
    begin
      for (int p = 0; p < NPM; p++)
        if (pm_rst_r[p])
          src_r[p] <= src_nxt[p];
    end
  end

  always_comb
  begin
    for (int p = 0; p < NPM; p++)
      conn[p] = (src_r[p] != SRC_NONE);
  end

  assign host_act = (src_r[PM_P10] == SRC_NONE);
  assign quad_act = (src_r[QUAD_BASE] == SRC_QUAD);

  ////////////////////////////////////////////////////////////////////////////////
  // Register reads
  always_comb
  begin
    rdata_nxt = '0;
    case (reg_addr_i)
      OFS_MACRO_CFG:
      begin
        rdata_nxt[QUAD_BIT]               = quad_serial_mode_enable_r;
        rdata_nxt[HOST_BIT]               = host_link_mode_enable_r;
        rdata_nxt[CU_SEL_LSB +: NDUAL]    = copper_sel_r;
        rdata_nxt[KEEP_LSB +: NDUAL]      = pcs_keep_r;
      end
      OFS_PORT_RST:   rdata_nxt[NPM-1:0]   = pm_rst_r;
      OFS_HDX_CFG:    rdata_nxt[NDUAL-1:0] = hdx_dis_r;
      OFS_MAP_STATUS:
      begin
        rdata_nxt[ST_CONN_LSB +: NPM]     = conn;
        rdata_nxt[ST_P10_OK]              = !host_act;
        rdata_nxt[ST_HOST_ACT]            = host_act;
        rdata_nxt[ST_QUAD_ACT]            = quad_act;
      end
      default:
      begin
        for (int n = 0; n < NPORT; n++)
          if (reg_addr_i == OFS_LPID_BASE + AW'(4 * n))
            rdata_nxt[PORT_W-1:0] = lpid_r[n];
      end
    endcase
  end

  always_ff @(posedge clk_sys_i)
  begin
    if (!rst_n_i)
      rdata_r <= '0;
    else if (reg_rd_i)
      rdata_r <= rdata_nxt;
    else
      rdata_r <= '0;
  end

  ////////////////////////////////////////////////////////////////////////////////
  // Receive paths toward port modules
  swpmm_rx_if pif [NPM] ();

  for (genvar g = 0; g < NPM; g++)
  begin : g_pm
    assign pif[g].src = src_r[g];
    if (g < NSER)
    begin : g_ser
      assign pif[g].ser = '{ser1g_rx_link_i[g], ser1g_rx_valid_i[g], ser1g_rx_data_i[g]};
    end
    else
    begin : g_noser
      assign pif[g].ser = LANE_IDLE;
    end
    if (g < NCU)
    begin : g_cu
      assign pif[g].cu = '{copper_rx_link_i[g], copper_rx_valid_i[g], copper_rx_data_i[g]};
    end
    else
    begin : g_nocu
      assign pif[g].cu = LANE_IDLE;
    end
    if (g >= QUAD_BASE && g < QUAD_BASE + NQUAD)
    begin : g_quad
      assign pif[g].quad = '{quad_rx_link_i[g-QUAD_BASE], quad_rx_valid_i[g-QUAD_BASE],
                             quad_rx_data_i[g-QUAD_BASE]};
    end
    else
    begin : g_noquad
      assign pif[g].quad = LANE_IDLE;
    end
    if (g == PM_P10)
    begin : g_hss
      assign pif[g].hss = '{hss_rx_link_i, hss_rx_valid_i, hss_rx_data_i};
    end
    else
    begin : g_nohss
      assign pif[g].hss = LANE_IDLE;
    end

    swpmm_port_sel u_sel (
      .clk_sys_i (clk_sys_i),
      .rst_n_i   (rst_n_i),
      .pif       (pif[g])
    );

    assign port_module_rx_data_o[g]  = pif[g].rx.data;
    assign port_module_rx_valid_o[g] = pif[g].rx.valid;
    assign port_module_rx_link_o[g]  = pif[g].rx.link;
  end

  ////////////////////////////////////////////////////////////////////////////////
  // Transmit paths toward macros
  always_ff @(posedge clk_sys_i)
  begin
    if (!rst_n_i)
    begin
      ser1g_tx_data_o   <= '0;
      ser1g_tx_valid_o  <= '0;
      copper_tx_data_o  <= '0;
      copper_tx_valid_o <= '0;
      quad_tx_data_o    <= '0;
      quad_tx_valid_o   <= '0;
    end
    else
    begin
      for (int i = 0; i < NSER; i++)
      begin
        ser1g_tx_data_o[i]  <= (src_r[i] == SRC_SER1G) ? port_module_tx_data_i[i] : '0;
        ser1g_tx_valid_o[i] <= (src_r[i] == SRC_SER1G) && port_module_tx_valid_i[i];
      end
      for (int i = 0; i < NCU; i++)
      begin
        copper_tx_data_o[i]  <= (src_r[i] == SRC_COPPER) ? port_module_tx_data_i[i] : '0;
        copper_tx_valid_o[i] <= (src_r[i] == SRC_COPPER) && port_module_tx_valid_i[i];
      end
      for (int k = 0; k < NQUAD; k++)
      begin
        quad_tx_data_o[k]  <= (src_r[QUAD_BASE+k] == SRC_QUAD) ?
                              port_module_tx_data_i[QUAD_BASE+k] : '0;
        quad_tx_valid_o[k] <= (src_r[QUAD_BASE+k] == SRC_QUAD) &&
                              port_module_tx_valid_i[QUAD_BASE+k];
      end
    end
  end

  always_ff @(posedge clk_sys_i)
  begin
    if (!rst_n_i)
    begin
      hss_tx_data_o        <= '0;
      hss_tx_valid_o       <= 1'b0;
      host_link_rx_data_o  <= '0;
      host_link_rx_valid_o <= 1'b0;
      host_link_rx_link_o  <= 1'b0;
    end
    else
    begin
      if (host_act)
      begin
        hss_tx_data_o  <= host_link_tx_data_i;
        hss_tx_valid_o <= host_link_tx_valid_i;
      end
      else
      begin
        hss_tx_data_o  <= port_module_tx_data_i[PM_P10];
        hss_tx_valid_o <= port_module_tx_valid_i[PM_P10];
      end
      host_link_rx_data_o  <= host_act ? hss_rx_data_i : '0;
      host_link_rx_valid_o <= host_act && hss_rx_valid_i;
      host_link_rx_link_o  <= host_act && hss_rx_link_i;
    end
  end

  ////////////////////////////////////////////////////////////////////////////////
  // Outputs
  assign reg_rdata_o                      = rdata_r;
  assign port_module_rst_o                = pm_rst_r;
  assign pcs_keep_active_o                = pcs_keep_r & copper_sel_r;
  assign half_duplex_quick_path_disable_o = hdx_dis_r;
  assign logical_port_identifier_o        = lpid_r;

endmodule : swpmm_top

`default_nettype wire

// File: swpmm_pkg.sv
// How it works
// - Every switch port carries a number 0 to 11 on a four-bit field.
// - Each external port feeds one port module, which feeds one interface macro.
// - Ports 0 to 3 pick either a one-gig serial macro or a copper transceiver.
// - A dual-media port can keep its serial coding layer active while on copper.
// - Port 11 is the internal CPU port with no port module and no macro.
// - Quad serial mode puts ports 4 to 7 on one high-speed macro as lanes.
// - Quad serial mode removes the normal one-gig serial links of ports 4 and 5; ports 6 and 7 have none.
// - Host-link mode gives the second high-speed macro to the host; port 10 unusable.
// - Each port holds a logical port number used by forwarding and rewriting.
`default_nettype none

package swpmm_pkg;

  ////////////////////////////////////////////////////////////////////////////////
  // Sizes
  localparam int NPORT     = 12;
  localparam int PORT_W    = 4;
  localparam int NPM       = 9;
  localparam int PM_P10    = 8;
  localparam int NSER      = 6;
  localparam int NCU       = 4;
  localparam int NQUAD     = 4;
  localparam int QUAD_BASE = 4;
  localparam int NDUAL     = 4;
  localparam int DW        = 8;
  localparam int AW        = 8;
  localparam int RW        = 32;

  ////////////////////////////////////////////////////////////////////////////////
  // Register offsets
  localparam logic [AW-1:0] OFS_MACRO_CFG  = 8'h00;
  localparam logic [AW-1:0] OFS_PORT_RST   = 8'h04;
  localparam logic [AW-1:0] OFS_HDX_CFG    = 8'h08;
  localparam logic [AW-1:0] OFS_MAP_STATUS = 8'h0c;
  localparam logic [AW-1:0] OFS_LPID_BASE  = 8'h10;

  // Macro configuration fields
  localparam int QUAD_BIT   = 0;
  localparam int HOST_BIT   = 1;
  localparam int CU_SEL_LSB = 2;
  localparam int KEEP_LSB   = 6;

  // Status fields
  localparam int ST_CONN_LSB = 0;
  localparam int ST_P10_OK   = 9;
  localparam int ST_HOST_ACT = 10;
  localparam int ST_QUAD_ACT = 11;

  // Reset values
  localparam logic [NPM-1:0]   PORT_RST_RST  = 9'h1ff;
  localparam logic [NDUAL-1:0] CU_SEL_RST    = 4'h0;
  localparam logic [NDUAL-1:0] KEEP_RST      = 4'h0;
  localparam logic [NDUAL-1:0] HDX_DIS_RST   = 4'h0;

  ////////////////////////////////////////////////////////////////////////////////
  // Types
  typedef enum logic [2:0] {
    SRC_NONE,
    SRC_SER1G,
    SRC_COPPER,
    SRC_QUAD,
    SRC_HSS
  } swpmm_src_t;

  typedef struct packed {
    logic          link;
    logic          valid;
    logic [DW-1:0] data;
  } swpmm_lane_t;

  localparam swpmm_lane_t LANE_IDLE = '{link: 1'b0, valid: 1'b0, data: 8'h00};

endpackage : swpmm_pkg

`default_nettype wire

// File: swpmm_rx_if.sv
`default_nettype none

interface swpmm_rx_if;
  import swpmm_pkg::*;

  swpmm_src_t  src;
  swpmm_lane_t ser;
  swpmm_lane_t cu;
  swpmm_lane_t quad;
  swpmm_lane_t hss;
  swpmm_lane_t rx;

  modport drv (output src, output ser, output cu, output quad, output hss, input rx);
  modport sel (input src, input ser, input cu, input quad, input hss, output rx);
endinterface : swpmm_rx_if

`default_nettype wire

// File: swpmm_port_sel.sv
`default_nettype none

module swpmm_port_sel
  import swpmm_pkg::*;
(
  // Clock and reset
  input  wire logic clk_sys_i,
  input  wire logic rst_n_i,
  // Candidate receive lanes
  swpmm_rx_if.sel   pif
);

  swpmm_lane_t rx_nxt;

  ////////////////////////////////////////////////////////////////////////////////
  // Receive select
  always_comb
  begin
    case (pif.src)
      SRC_SER1G:  rx_nxt = pif.ser;
      SRC_COPPER: rx_nxt = pif.cu;
      SRC_QUAD:   rx_nxt = pif.quad;
      SRC_HSS:    rx_nxt = pif.hss;
      SRC_NONE:   rx_nxt = LANE_IDLE;
      default:    rx_nxt = LANE_IDLE;
    endcase
  end

  always_ff @(posedge clk_sys_i)
  begin
    if (!rst_n_i)
      pif.rx <= LANE_IDLE;
    else
      pif.rx <= rx_nxt;
  end

endmodule : swpmm_port_sel

`default_nettype wire

// File: swpmm_props.sv
`default_nettype none

module swpmm_props
  import swpmm_pkg::*;
(
  // Clock and reset
  input  wire logic                                         clk_sys_i,
  input  wire logic                                         rst_n_i,
  // Port modules
  input  wire logic [swpmm_pkg::NPM-1:0]                    port_module_tx_valid_i,
  input  wire logic [swpmm_pkg::NPM-1:0][swpmm_pkg::DW-1:0] port_module_rx_data_o,
  input  wire logic [swpmm_pkg::NPM-1:0]                    port_module_rx_valid_o,
  input  wire logic [swpmm_pkg::NPM-1:0]                    port_module_rx_link_o,
  input  wire logic [swpmm_pkg::NPM-1:0]                    port_module_rst_o,
  // Macros
  input  wire logic [swpmm_pkg::NSER-1:0][swpmm_pkg::DW-1:0] ser1g_rx_data_i,
  input  wire logic [swpmm_pkg::NSER-1:0]                    ser1g_tx_valid_o,
  input  wire logic [swpmm_pkg::NCU-1:0][swpmm_pkg::DW-1:0]  copper_rx_data_i,
  input  wire logic [swpmm_pkg::NCU-1:0]                     copper_tx_valid_o,
  input  wire logic [swpmm_pkg::NQUAD-1:0]                   quad_rx_link_i,
  input  wire logic [swpmm_pkg::NQUAD-1:0]                   quad_tx_valid_o,
  input  wire logic                                          hss_tx_valid_o,
  // Host link and ids
  input  wire logic                                          host_link_tx_valid_i,
  input  wire logic                                          host_link_rx_valid_o,
  input  wire logic [swpmm_pkg::NPORT-1:0][swpmm_pkg::PORT_W-1:0] logical_port_identifier_o
);
  timeunit 1ns;
  timeprecision 1ps;
  import swpmm_pkg::*;

  default clocking cb @(posedge clk_sys_i);
  endclocking
  default disable iff (!rst_n_i);

  ////////////////////////////////////////////////////////////////////////////////
  // Assertions
  port0_src_a : assert property (port_module_rx_valid_o[0] |->
    (port_module_rx_data_o[0] == $past(copper_rx_data_i[0]))
    || (port_module_rx_data_o[0] == $past(ser1g_rx_data_i[0])))
    else $error("port 0 receive data from no macro");
  dual_tx_excl_a : assert property (!(copper_tx_valid_o[0] && ser1g_tx_valid_o[0]))
    else $error("port 0 drives both media");
  quad_tx_src_a : assert property (quad_tx_valid_o[1] |-> $past(port_module_tx_valid_i[5]))
    else $error("quad lane 1 valid without port 5");
  port6_rx_src_a : assert property (port_module_rx_link_o[6] |-> $past(quad_rx_link_i[2]))
    else $error("port 6 link without quad lane 2");
  quad_ser_excl_a : assert property (!(quad_tx_valid_o[0] && ser1g_tx_valid_o[4]))
    else $error("port 4 on two macros");
  hss_tx_src_a : assert property (hss_tx_valid_o |->
    $past(port_module_tx_valid_i[8] || host_link_tx_valid_i))
    else $error("second macro valid without source");
  host_p10_excl_a : assert property (!(host_link_rx_valid_o && port_module_rx_valid_o[8]))
    else $error("host link and port 10 share macro");
  lpid_rst_a : assert property ($rose(rst_n_i) |->
    (logical_port_identifier_o[11] == 4'hb) && (logical_port_identifier_o[3] == 4'h3))
    else $error("logical id not port number after reset");
  prst_rst_a : assert property ($rose(rst_n_i) |-> port_module_rst_o == 9'h1ff)
    else $error("port modules not held in reset");

  ////////////////////////////////////////////////////////////////////////////////
  // Covers
  quad_c : cover property (quad_tx_valid_o[1]);
  host_c : cover property (hss_tx_valid_o && host_link_tx_valid_i);
  cu_c   : cover property (copper_tx_valid_o[0]);
endmodule // swpmm_props

bind swpmm_top swpmm_props i_swpmm_props (
  .clk_sys_i(clk_sys_i), .rst_n_i(rst_n_i), .port_module_tx_valid_i(port_module_tx_valid_i),
  .port_module_rx_data_o(port_module_rx_data_o), .port_module_rx_valid_o(port_module_rx_valid_o),
  .port_module_rx_link_o(port_module_rx_link_o), .port_module_rst_o(port_module_rst_o),
  .ser1g_rx_data_i(ser1g_rx_data_i), .ser1g_tx_valid_o(ser1g_tx_valid_o),
  .copper_rx_data_i(copper_rx_data_i), .copper_tx_valid_o(copper_tx_valid_o),
  .quad_rx_link_i(quad_rx_link_i), .quad_tx_valid_o(quad_tx_valid_o),
  .hss_tx_valid_o(hss_tx_valid_o), .host_link_tx_valid_i(host_link_tx_valid_i),
  .host_link_rx_valid_o(host_link_rx_valid_o),
  .logical_port_identifier_o(logical_port_identifier_o)
);

`default_nettype wire

// File: swpmm_macro_model.sv
`default_nettype none

module swpmm_macro_model
  import swpmm_pkg::*;
(
  // Clock and reset
  input  wire logic                                          clk_sys_i,
  input  wire logic                                          rst_n_i,
  // Receive toward the mapping
  output logic      [swpmm_pkg::NSER-1:0][swpmm_pkg::DW-1:0] ser1g_rx_data_o,
  output logic      [swpmm_pkg::NSER-1:0]                    ser1g_rx_valid_o,
  output logic      [swpmm_pkg::NSER-1:0]                    ser1g_rx_link_o,
  output logic      [swpmm_pkg::NCU-1:0][swpmm_pkg::DW-1:0]  copper_rx_data_o,
  output logic      [swpmm_pkg::NCU-1:0]                     copper_rx_valid_o,
  output logic      [swpmm_pkg::NCU-1:0]                     copper_rx_link_o,
  output logic      [swpmm_pkg::NQUAD-1:0][swpmm_pkg::DW-1:0] quad_rx_data_o,
  output logic      [swpmm_pkg::NQUAD-1:0]                    quad_rx_valid_o,
  output logic      [swpmm_pkg::NQUAD-1:0]                    quad_rx_link_o,
  output logic      [swpmm_pkg::DW-1:0]                       hss_rx_data_o,
  output logic                                                hss_rx_valid_o,
  output logic                                                hss_rx_link_o
);
  timeunit 1ns;
  timeprecision 1ps;
  import swpmm_pkg::*;

  logic [7:0] cnt_r;

  always_ff @(posedge clk_sys_i)
  begin
    if (!rst_n_i) cnt_r <= 8'h00;
    else cnt_r <= cnt_r + 8'h01;
  end

  // Every macro lane shows its own byte, changing each cycle
  always_comb
  begin
    for (int k = 0; k < NSER; k++)
    begin
      ser1g_rx_data_o[k]  = cnt_r ^ 8'(k * 17);
      ser1g_rx_valid_o[k] = cnt_r[0];
      ser1g_rx_link_o[k]  = cnt_r[7:4] != 4'hf;
    end
    for (int k = 0; k < NCU; k++)
    begin
      copper_rx_data_o[k]  = cnt_r ^ 8'(8'h80 + k * 17);
      copper_rx_valid_o[k] = ~cnt_r[0];
      copper_rx_link_o[k]  = cnt_r[7:4] != 4'he;
    end
    for (int k = 0; k < NQUAD; k++)
    begin
      quad_rx_data_o[k]  = cnt_r ^ 8'(8'h40 + k * 17);
      quad_rx_valid_o[k] = cnt_r[1];
      quad_rx_link_o[k]  = cnt_r[7:4] != 4'hd;
    end
    hss_rx_data_o  = cnt_r ^ 8'hc0;
    hss_rx_valid_o = cnt_r[1];
    hss_rx_link_o  = 1'b1;
  end
endmodule // swpmm_macro_model

`default_nettype wire

// File: swpmm_top_tb.sv
`default_nettype none

module swpmm_top_tb;
  timeunit 1ns;
  timeprecision 1ps;
  import swpmm_pkg::*;

  typedef struct {logic [7:0] addr; logic [31:0] exp;} swpmm_row_t;

  logic clk_sys_i = 1'b0;
  logic rst_n_i = 1'b0;
  logic [AW-1:0] reg_addr_i = 8'h00;
  logic [RW-1:0] reg_wdata_i = 32'h0;
  logic reg_wr_i = 1'b0;
  logic reg_rd_i = 1'b0;
  logic [RW-1:0] reg_rdata_o;
  logic [NPM-1:0][DW-1:0] pm_tx_data, pm_rx_data;
  logic [NPM-1:0] pm_tx_valid = 9'h1ff;
  logic [NPM-1:0] pm_rx_valid, pm_rx_link, pm_rst;
  logic [NDUAL-1:0] keep_act, hdx_dis;
  logic [NSER-1:0][DW-1:0] s_rxd, s_txd;
  logic [NSER-1:0] s_rxv, s_rxl, s_txv;
  logic [NCU-1:0][DW-1:0] c_rxd, c_txd;
  logic [NCU-1:0] c_rxv, c_rxl, c_txv;
  logic [NQUAD-1:0][DW-1:0] q_rxd, q_txd;
  logic [NQUAD-1:0] q_rxv, q_rxl, q_txv;
  logic [DW-1:0] h_rxd, h_txd, hl_rxd;
  logic [DW-1:0] hl_txd = 8'h77;
  logic h_rxv, h_rxl, h_txv, hl_rxv, hl_rxl;
  logic hl_txv = 1'b1;
  logic [NPORT-1:0][PORT_W-1:0] lpid;
  logic [7:0] prev;
  int num_errors = 0;
  int n_compared = 0;
  swpmm_row_t rows [7] = '{'{8'h00, 32'h0}, '{8'h04, 32'h1ff}, '{8'h08, 32'h0},
    '{8'h0c, 32'h33f}, '{8'h14, 32'h1}, '{8'h3c, 32'hb}, '{8'h80, 32'h0}};

  always #20 clk_sys_i = ~clk_sys_i;

  initial
  begin
    for (int k = 0; k < NPM; k++) pm_tx_data[k] = 8'(8'h20 + k);
  end

  swpmm_macro_model i_swpmm_macro_model (.clk_sys_i(clk_sys_i), .rst_n_i(rst_n_i),
    .ser1g_rx_data_o(s_rxd), .ser1g_rx_valid_o(s_rxv), .ser1g_rx_link_o(s_rxl),
    .copper_rx_data_o(c_rxd), .copper_rx_valid_o(c_rxv), .copper_rx_link_o(c_rxl),
    .quad_rx_data_o(q_rxd), .quad_rx_valid_o(q_rxv), .quad_rx_link_o(q_rxl),
    .hss_rx_data_o(h_rxd), .hss_rx_valid_o(h_rxv), .hss_rx_link_o(h_rxl));

  swpmm_top i_swpmm_top (.clk_sys_i(clk_sys_i), .rst_n_i(rst_n_i), .reg_addr_i(reg_addr_i),
    .reg_wdata_i(reg_wdata_i), .reg_wr_i(reg_wr_i), .reg_rd_i(reg_rd_i),
    .reg_rdata_o(reg_rdata_o), .port_module_tx_data_i(pm_tx_data),
    .port_module_tx_valid_i(pm_tx_valid), .port_module_rx_data_o(pm_rx_data),
    .port_module_rx_valid_o(pm_rx_valid), .port_module_rx_link_o(pm_rx_link),
    .port_module_rst_o(pm_rst), .pcs_keep_active_o(keep_act),
    .half_duplex_quick_path_disable_o(hdx_dis), .ser1g_rx_data_i(s_rxd),
    .ser1g_rx_valid_i(s_rxv), .ser1g_rx_link_i(s_rxl), .ser1g_tx_data_o(s_txd),
    .ser1g_tx_valid_o(s_txv), .copper_rx_data_i(c_rxd), .copper_rx_valid_i(c_rxv),
    .copper_rx_link_i(c_rxl), .copper_tx_data_o(c_txd), .copper_tx_valid_o(c_txv),
    .quad_rx_data_i(q_rxd), .quad_rx_valid_i(q_rxv), .quad_rx_link_i(q_rxl),
    .quad_tx_data_o(q_txd), .quad_tx_valid_o(q_txv), .hss_rx_data_i(h_rxd),
    .hss_rx_valid_i(h_rxv), .hss_rx_link_i(h_rxl), .hss_tx_data_o(h_txd),
    .hss_tx_valid_o(h_txv), .host_link_tx_data_i(hl_txd), .host_link_tx_valid_i(hl_txv),
    .host_link_rx_data_o(hl_rxd), .host_link_rx_valid_o(hl_rxv),
    .host_link_rx_link_o(hl_rxl), .logical_port_identifier_o(lpid));

  ////////////////////////////////////////////////////////////////////////////////
  // Tasks
  task automatic chk(input string nm, input logic [31:0] seen, input logic [31:0] exp);
    n_compared++;
    if (seen !== exp)
    begin
      num_errors++;
      $display("[FAIL] %s expected %h seen %h", nm, exp, seen);
    end
  endtask

  task automatic wr(input logic [7:0] a, input logic [31:0] d);
    @(posedge clk_sys_i);
    reg_addr_i <= a;
    reg_wdata_i <= d;
    reg_wr_i <= 1'b1;
    @(posedge clk_sys_i);
    reg_wr_i <= 1'b0;
  endtask

  task automatic rd(input logic [7:0] a, input logic [31:0] exp);
    @(posedge clk_sys_i);
    reg_addr_i <= a;
    reg_rd_i <= 1'b1;
    @(posedge clk_sys_i);
    reg_rd_i <= 1'b0;
    @(negedge clk_sys_i);
    chk("read data", reg_rdata_o, exp);
  endtask

  // Port reset set then cleared on all nine port modules
  task automatic port_cycle();
    wr(OFS_PORT_RST, 32'h1ff);
    wr(OFS_PORT_RST, 32'h0);
    repeat (3) @(posedge clk_sys_i);
    @(negedge clk_sys_i);
  endtask

  task automatic end_of_test();
    $display("compared %0d mismatches %0d", n_compared, num_errors);
    if (num_errors == 0 && n_compared > 0)
      $display("*** PASS ***");
    else
      $display("*** FAIL ***");
    $finish;
  endtask

  initial
  begin
    repeat (5000) @(posedge clk_sys_i);
    num_errors++;
    end_of_test();
  end

  ////////////////////////////////////////////////////////////////////////////////
  // Sequence
  initial
  begin
    repeat (2) @(posedge clk_sys_i);
    rst_n_i <= 1'b1;
    foreach (rows[i]) rd(rows[i].addr, rows[i].exp);
    wr(OFS_MACRO_CFG, 32'h44);
    wr(OFS_HDX_CFG, 32'h1);
    port_cycle();
    prev = c_rxd[0];
    @(negedge clk_sys_i);
    chk("port 0 copper rx", 32'(pm_rx_data[0]), 32'(prev));
    chk("port 0 copper tx", 32'(c_txd[0]), 32'h20);
    chk("port 0 serial tx idle", 32'(s_txv[0]), 32'h0);
    chk("port 1 serial tx", 32'(s_txd[1]), 32'h21);
    chk("keep active", 32'(keep_act), 32'h1);
    chk("hdx disable", 32'(hdx_dis), 32'h1);
    chk("port reset released", 32'(pm_rst), 32'h0);
    chk("port 6 unconnected", 32'({pm_rx_link[6], pm_rx_valid[6]}), 32'h0);
    chk("port 10 tx", 32'(h_txd), 32'h28);
    wr(OFS_MACRO_CFG, 32'h45);
    port_cycle();
    rd(OFS_MAP_STATUS, 32'hbff);
    for (int k = 0; k < NQUAD; k++)
      chk("quad lane tx", 32'(q_txd[k]), 32'(8'h24 + k));
    chk("port 4 serial tx removed", 32'(s_txv[4]), 32'h0);
    prev = q_rxd[3];
    @(negedge clk_sys_i);
    chk("port 7 quad rx", 32'(pm_rx_data[7]), 32'(prev));
    wr(OFS_MACRO_CFG, 32'h47);
    rd(OFS_MAP_STATUS, 32'hbff);
    port_cycle();
    rd(OFS_MAP_STATUS, 32'hcff);
    chk("host tx", 32'(h_txd), 32'h77);
    chk("port 10 idle", 32'({pm_rx_link[8], pm_rx_valid[8]}), 32'h0);
    prev = h_rxd;
    @(negedge clk_sys_i);
    chk("host rx", 32'({hl_rxl, hl_rxd}), 32'({1'b1, prev}));
    wr(8'h1c, 32'h2);
    rd(8'h1c, 32'h2);
    chk("logical id", 32'(lpid[3]), 32'h2);
    @(posedge clk_sys_i);
    rst_n_i <= 1'b0;
    repeat (2) @(posedge clk_sys_i);
    @(negedge clk_sys_i);
    chk("port reset value", 32'(pm_rst), 32'h1ff);
    chk("logical id reset", 32'(lpid[3]), 32'h3);
    @(posedge clk_sys_i);
    rst_n_i <= 1'b1;
    repeat (2) @(posedge clk_sys_i);
    end_of_test();
  end
endmodule // swpmm_top_tb

`default_nettype wire
